// [sccl_pkg.sv]
// Constants, carrier types and field layouts of the synthesizer configuration logic.
// Assumes one clock domain, with every pin input already synchronous to that clock.
package sccl_pkg;

    // Register byte offsets on the AXI4-Lite port.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_FREQ = 8'h08;

    // Control register layout and value after reset.
    localparam int CTRL_OE_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // Configuration latch values after reset, matching the levels of open pins.
    localparam logic [8:0] M_RST = 9'h1FF;
    localparam logic [1:0] N_RST = 2'h3;
    localparam logic [2:0] T_RST = 3'h0;

    // Serial chain length.
    localparam int CHAIN_W = 14;

    // Output frequency step in kHz per loop divider count at divide-by-1, 16 MHz reference.
    localparam logic [19:0] STEP_KHZ = 20'h003E8;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Configuration word in serial chain order, most significant field first.
    typedef struct packed {
        logic [2:0] t;
        logic [1:0] n;
        logic [8:0] m;
    } sccl_cfg_t;

    // Output gate states.
    typedef enum logic [1:0] {
        GATE_OFF = 2'b00,
        GATE_ON = 2'b01
    } sccl_gate_t;

endpackage

// [sccl_core.sv]
// Configuration latches, output divider, output gate, test mux and AXI4-Lite registers.
// Assumes all pins are synchronous to mclk_i, which stands in for the oscillator clock.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module sccl_core
    import sccl_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Serial configuration pins.
    input wire logic s_load_i,
    input wire logic s_data_i,
    input wire logic s_clock_i,
    // Parallel configuration pins.
    input wire logic p_load_i,
    input wire logic [8:0] m_i,
    input wire logic [1:0] n_i,
    input wire logic oe_i,
    // Synthesized and test outputs.
    output logic fout_o,
    output logic test_o,
    // AXI4-Lite write channels.
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [7:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    // AXI4-Lite read channels.
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [7:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o
);

    logic [CHAIN_W-1:0] shift_q;
    logic sclk_q;
    sccl_cfg_t cfg_q;
    sccl_cfg_t cfg_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic fout_q;
    logic fout_d;
    sccl_gate_t gate_q;
    sccl_gate_t gate_d;
    logic test_q;
    logic [19:0] freq_q;
    logic [31:0] ctrl_q;
    logic aw_q;
    logic [7:0] awaddr_q;
    logic w_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Serial shift clock edge, seen as a level change on a synchronous pin.
    wire sclk_rise = s_clock_i & ~sclk_q;

    // Serial path has priority when both strobes are open at once.
    wire ser_open = s_load_i;
    wire par_open = ~s_load_i & ~p_load_i;
    wire sccl_cfg_t cfg_ser = sccl_cfg_t'(shift_q);
    wire sccl_cfg_t cfg_par = sccl_cfg_t'({cfg_q.t, n_i, m_i});

    wire [2:0] div_last = 3'((4'h1 << cfg_q.n) - 4'h1);
    wire tick = cnt_q >= div_last;
    wire en = oe_i & ctrl_q[CTRL_OE_BIT];
    wire gate_on = gate_q == GATE_ON;

    wire [19:0] freq_d = (20'(cfg_q.m) * STEP_KHZ) >> cfg_q.n;

    // Test output sources, indexed by the serial-only test field.
    wire [7:0] test_src = {p_load_i, s_load_i, gate_on, tick, shift_q[CHAIN_W-1], 1'b0, 1'b1, fout_q};

    // AXI decode.
    wire aw_take = awvalid_i & awready_o;
    wire w_take = wvalid_i & wready_o;
    wire ar_take = arvalid_i & arready_o;
    wire wr_do = aw_q & w_q & ~bvalid_q;
    wire wr_ctrl = awaddr_q == ADDR_CTRL;
    wire rd_ctrl = araddr_i == ADDR_CTRL;
    wire rd_stat = araddr_i == ADDR_STAT;
    wire rd_freq = araddr_i == ADDR_FREQ;
    wire rd_hit = rd_ctrl | rd_stat | rd_freq;
    wire [31:0] stat_word = {17'h00000, gate_on, cfg_q};
    wire [31:0] rd_word = rd_ctrl ? ctrl_q : rd_stat ? stat_word : rd_freq ? {12'h000, freq_q} : 32'h0000_0000;

    // Ready is withheld while the clock enable is low so no handshake is lost during a freeze.
    assign awready_o = ce_i & ~aw_q & ~bvalid_q;
    assign wready_o = ce_i & ~w_q & ~bvalid_q;
    assign arready_o = ce_i & ~rvalid_q;
    assign bvalid_o = bvalid_q;
    assign bresp_o = bresp_q;
    assign rvalid_o = rvalid_q;
    assign rdata_o = rdata_q;
    assign rresp_o = rresp_q;
    assign fout_o = fout_q;
    assign test_o = test_q;

    assign cnt_d = tick ? 3'h0 : 3'(cnt_q + 3'h1);
    assign cfg_d = ser_open ? cfg_ser : par_open ? cfg_par : cfg_q;

    // Output gate: stop only after a high phase ends, start only on a divider boundary.
    always_comb begin
        gate_d = gate_q;
        fout_d = fout_q;
        if (tick) begin
            unique case (gate_q)
                GATE_ON: begin
                    fout_d = ~fout_q;
                    if (fout_q && !en) begin
                        gate_d = GATE_OFF;
                    end
                end
                default: begin
                    if (en) begin
                        gate_d = GATE_ON;
                        fout_d = 1'b1;
                    end
                end
            endcase
        end
    end

    // Shift chain resets to the open-pin level of the serial pins.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= '0;
            sclk_q <= 1'b0;
        end else if (ce_i) begin
            sclk_q <= s_clock_i;
            if (sclk_rise) begin
                shift_q <= {shift_q[CHAIN_W-2:0], s_data_i};
            end
        end
    end

    // The latches are modelled as flops that follow while open and keep the last value once shut.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= sccl_cfg_t'({T_RST, N_RST, M_RST});
        end else if (ce_i) begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 3'h0;
            fout_q <= 1'b0;
            gate_q <= GATE_OFF;
            test_q <= 1'b0;
            freq_q <= 20'h00000;
        end else if (ce_i) begin
            cnt_q <= cnt_d;
            fout_q <= fout_d;
            gate_q <= gate_d;
            test_q <= test_src[cfg_q.t];
            freq_q <= freq_d;
        end
    end

    // Write address and data are held independently and joined for one write.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (ce_i) begin
            if (aw_take) begin
                aw_q <= 1'b1;
                awaddr_q <= awaddr_i;
            end else if (wr_do) begin
                aw_q <= 1'b0;
            end
            if (w_take) begin
                w_q <= 1'b1;
                wdata_q <= wdata_i;
                wstrb_q <= wstrb_i;
            end else if (wr_do) begin
                w_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce_i) begin
            if (wr_do) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
                if (wr_ctrl && wstrb_q[0]) begin
                    ctrl_q[CTRL_OE_BIT] <= wdata_q[CTRL_OE_BIT];
                end
            end else if (bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ce_i) begin
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_div8;
        ce_i && cfg_q.n == 2'b11;
    endsequence

    property p_div_period;
        (tick and s_div8) ##1 s_div8 [*8] |-> tick;
    endproperty
    a_div_period: assert property (p_div_period) else $error("divide-by-8 tick spacing wrong");

    property p_toggle;
        ce_i && tick && gate_on |=> fout_q != $past(fout_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not toggle on divider tick");

    property p_shift;
        ce_i && sclk_rise |=> shift_q == {$past(shift_q[CHAIN_W-2:0]), $past(s_data_i)};
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not shifted on clock rise");

    property p_ser_pass;
        ce_i && s_load_i |=> cfg_q == $past(shift_q);
    endproperty
    a_ser_pass: assert property (p_ser_pass) else $error("serial latch not transparent");

    property p_hold;
        ce_i && !s_load_i && p_load_i |=> $stable(cfg_q);
    endproperty
    a_hold: assert property (p_hold) else $error("configuration changed while latches shut");

    property p_par_pass;
        ce_i && !s_load_i && !p_load_i |=>
            cfg_q.m == $past(m_i) && cfg_q.n == $past(n_i) && cfg_q.t == $past(cfg_q.t);
    endproperty
    a_par_pass: assert property (p_par_pass) else $error("parallel latch not transparent");

    property p_off_low;
        !gate_on |-> !fout_q;
    endproperty
    a_off_low: assert property (p_off_low) else $error("disabled output not held low");

    property p_clean_start;
        $rose(fout_q) |-> $past(ce_i && tick);
    endproperty
    a_clean_start: assert property (p_clean_start) else $error("output rose off a divider boundary");

    property p_freq;
        ce_i |=> freq_q == 20'((20'($past(cfg_q.m)) * STEP_KHZ) >> $past(cfg_q.n));
    endproperty
    a_freq: assert property (p_freq) else $error("frequency report mismatch");

    property p_freeze;
        !ce_i |=> $stable(cfg_q) && $stable(fout_q) && $stable(shift_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

    property p_clean_stop;
        $fell(gate_on) |-> $fell(fout_q);
    endproperty
    a_clean_stop: assert property (p_clean_stop) else $error("output stopped outside a high phase end");

    property p_stay_off;
        ce_i && !gate_on && !en |=> !gate_on;
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("disabled output restarted");

    property p_test_one;
        ce_i && cfg_q.t == 3'h1 |=> test_q;
    endproperty
    a_test_one: assert property (p_test_one) else $error("test output not high for select one");

endmodule

// [sccl_ctl_model.sv]
// Behavioural controller that drives the three-wire serial configuration pins.
// Assumes the bench calls send and that mclk_i is the device clock.
`timescale 1ns/1ps

module sccl_ctl_model (
    // Clock.
    input wire logic mclk_i,
    // Serial pins towards the device.
    output logic s_load_o,
    output logic s_data_o,
    output logic s_clock_o
);
    initial begin
        s_load_o = 1'b0;
        s_data_o = 1'b0;
        s_clock_o = 1'b0;
    end

    task automatic send(input logic [13:0] w);
        for (int i = 13; i >= 0; i--) begin
            @(posedge mclk_i);
            s_data_o <= w[i];
            s_clock_o <= 1'b0;
            @(posedge mclk_i);
            s_clock_o <= 1'b1;
        end
        @(posedge mclk_i);
        s_clock_o <= 1'b0;
        s_load_o <= 1'b1;
        repeat (2) @(posedge mclk_i);
        s_load_o <= 1'b0;
        @(posedge mclk_i);
        // Data goes back to its pull-down level only after the strobe has closed.
        s_data_o <= 1'b0;
    endtask
endmodule

// [sccl_core_test.sv]
// Self-checking bench for sccl_core: pins, divider, gate and AXI4-Lite registers.
// Assumes sccl_pkg is compiled first; ce_i is dropped once to check that fout_o holds and awready_o stays low.
`timescale 1ns/1ps

module sccl_core_test;
    import sccl_pkg::*;
    logic mclk_i, rst_i, ce, p_load, oe, awvalid, wvalid, bready, arvalid, rready;
    logic s_load, s_data, s_clock, fout, test, awready, wready, bvalid, arready, rvalid;
    logic [8:0] m;
    logic [1:0] n, bresp, rresp, r;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    int miscompares, comparisons, c;

    sccl_ctl_model ctl (.mclk_i(mclk_i), .s_load_o(s_load), .s_data_o(s_data), .s_clock_o(s_clock));
    sccl_core u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .s_load_i(s_load), .s_data_i(s_data),
        .s_clock_i(s_clock), .p_load_i(p_load), .m_i(m), .n_i(n), .oe_i(oe), .fout_o(fout), .test_o(test),
        .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready),
        .wdata_i(wdata), .wstrb_i(4'hF), .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
        .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .rvalid_o(rvalid), .rready_i(rready),
        .rdata_o(rdata), .rresp_o(rresp));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    task results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge mclk_i);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge mclk_i);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Ends on the sample edge of a rising output after at least one low sample.
    task rise(output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk_i);
            cnt++;
        end while (fout !== 1'b0 && cnt < 200);
        do begin
            @(posedge mclk_i);
            cnt++;
        end while (fout !== 1'b1 && cnt < 200);
    endtask

    task plod(input logic [8:0] mv, input logic [1:0] nv);
        @(posedge mclk_i);
        m <= mv;
        n <= nv;
        p_load <= 1'b0;
        repeat (3) @(posedge mclk_i);
        p_load <= 1'b1;
        repeat (2) @(posedge mclk_i);
        m <= ~mv;
        n <= ~nv;
        repeat (3) @(posedge mclk_i);
    endtask

    task t_reset;
        rd(ADDR_STAT, v, r);
        chk(v[13:0], 14'h07FF);
        chk(r, RESP_OKAY);
        rd(ADDR_CTRL, v, r);
        chk(v, CTRL_RST);
    endtask

    task t_par;
        plod(9'h12C, 2'h2);
        rd(ADDR_STAT, v, r);
        chk(v[10:0], {2'h2, 9'h12C});
        rd(ADDR_FREQ, v, r);
        chk(v, 32'h000124F8);
    endtask

    task t_ser;
        ctl.send({3'h1, 2'h0, 9'h123});
        rd(ADDR_STAT, v, r);
        chk(v[13:0], 14'h0923);
        chk(test, 1'b1);
        ctl.send({3'h2, 2'h0, 9'h123});
        rd(ADDR_STAT, v, r);
        chk(test, 1'b0);
        ctl.send({3'h7, 2'h0, 9'h123});
        rd(ADDR_STAT, v, r);
        chk(test, 1'b1);
    endtask

    task t_div;
        for (int k = 0; k < 4; k++) begin
            plod(9'h12C, k[1:0]);
            rise(c);
            rise(c);
            chk(c, 2 << k);
        end
    endtask

    // With divide-by-8 left selected, an unfrozen output would toggle inside the ten checked cycles.
    task t_freeze;
        logic f;
        @(posedge mclk_i);
        ce <= 1'b0;
        @(posedge mclk_i);
        f = fout;
        chk(awready, 1'b0);
        repeat (10) begin
            @(posedge mclk_i);
            chk(fout, f);
        end
        ce <= 1'b1;
    endtask

    task t_gate;
        @(posedge mclk_i);
        oe <= 1'b0;
        repeat (20) @(posedge mclk_i);
        c = 0;
        repeat (20) begin
            @(posedge mclk_i);
            if (fout !== 1'b0) c++;
        end
        chk(c, 0);
        oe <= 1'b1;
        rise(c);
        rise(c);
        chk(c, 16);
        wr(ADDR_CTRL, 32'h0, r);
        chk(r, RESP_OKAY);
        repeat (20) @(posedge mclk_i);
        chk(fout, 1'b0);
        wr(8'h0C, 32'h1, r);
        chk(r, RESP_SLVERR);
        rd(8'h0C, v, r);
        chk(v, 32'h0000_0000);
        chk(r, RESP_SLVERR);
    endtask

    initial begin
        rst_i = 1'b1;
        ce = 1'b1;
        p_load = 1'b1;
        m = 9'h1FF;
        n = 2'h3;
        oe = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_par();
        t_ser();
        t_div();
        t_freeze();
        t_gate();
        results();
    end

    initial begin
        #400000;
        miscompares++;
        results();
    end
endmodule
